// [inc/ppd_pkg.sv]
// constants and types shared by the push-button pulse dialler
`default_nettype none
package ppd_pkg;
  localparam int MCLK_KHZ = 40000;
  localparam int REF_KHZ = 20;
  localparam logic [11:0] TICK_DIV = 12'(MCLK_KHZ / REF_KHZ);
  localparam int PULSE_DIV = 2047;
  localparam int RATIO_GND_PCT = 62;
  localparam int RATIO_OPEN_PCT = 66;
  localparam int PAUSE_GND_MS = 833;
  localparam int PAUSE_OPEN_MS = 433;
  localparam int DEB_MS = 10;
  localparam int TCNT_W = 15;
  localparam logic [TCNT_W-1:0] PERIOD_LAST = 15'(PULSE_DIV - 1);
  localparam logic [TCNT_W-1:0] BRK_GND = 15'(PULSE_DIV * RATIO_GND_PCT / 100);
  localparam logic [TCNT_W-1:0] BRK_OPEN = 15'(PULSE_DIV * RATIO_OPEN_PCT / 100);
  localparam logic [TCNT_W-1:0] PAUSE_GND = 15'(PAUSE_GND_MS * REF_KHZ);
  localparam logic [TCNT_W-1:0] PAUSE_OPEN = 15'(PAUSE_OPEN_MS * REF_KHZ);
  localparam logic [7:0] DEB_TICKS = 8'(DEB_MS * REF_KHZ);
  localparam int PTR_W = 5;
  localparam logic [PTR_W-1:0] STORE_DEPTH = 5'h12;
  localparam logic [PTR_W-1:0] HOLD_DEPTH = 5'h11;
  localparam logic [3:0] CODE_RSV_F = 4'hF;
  localparam logic [3:0] CODE_RSV_E = 4'hE;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_DECODE, ST_BREAK, ST_MAKE, ST_PAUSE
  } ppd_state_t;
endpackage : ppd_pkg
`default_nettype wire

// [inc/ppd_store_if.sv]
// figure store port between the dialler control and the store memory
`default_nettype none
interface ppd_store_if;
  logic wr_en;
  logic [ppd_pkg::PTR_W-1:0] wr_addr;
  logic [3:0] wr_data;
  logic [ppd_pkg::PTR_W-1:0] rd_addr;
  logic [3:0] rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : ppd_store_if
`default_nettype wire

// [rtl/ppd_fig_store.sv]
// four lanes of eighteen figure cells with a registered read port
`default_nettype none
module ppd_fig_store (
  input wire logic mclk,
  input wire logic ce,
  ppd_store_if.mem st
);
  logic [3:0] cell_reg [ppd_pkg::STORE_DEPTH];

  always_ff @(posedge mclk) begin
    if (ce && st.wr_en) begin
      cell_reg[st.wr_addr] <= st.wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (ce) begin
      st.rd_data <= cell_reg[st.rd_addr];
    end
  end
endmodule : ppd_fig_store
`default_nettype wire

// [rtl/ppd_dialler.sv]
// push-button to loop-disconnect pulse dialler control
`default_nettype none
// Functional notes
// - Key codes go into a four-lane, eighteen-figure store.
// - Debounced strobe enters each key press exactly once.
// - Each stored figure loads a counter; that many pulses are sent.
// - Interdigital interval enforced; off-normal drives during dialling.
// - Off-normal released during each interdigital pause.
// - Dial-pulse and off-normal outputs drive external relay transistors.
// - Dial pulse period is 2047 device clock periods.
// - Reset clears all control state; reset length set outside.
// - Negative logic: low pin level is one.
// - Codes 1111 and 1110 are never stored as figures.
// - Key code to figure decoding per fixed table with don't-cares.
// - Register control at zero blocks output and retains up to 17 figures.
// - Hold pulses recall figures; key entry continues meanwhile.
// - Pause option: grounded 833 ms, open 433 ms.
// - Ratio option: grounded break 0.62, open 0.66.
module ppd_dialler #(
  parameter logic [11:0] tick_div = ppd_pkg::TICK_DIV
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] key_n,
  input wire logic strobe_n,
  input wire logic hold_pin,
  input wire logic pause_gnd,
  input wire logic ratio_gnd,
  output logic dial_pulse_n,
  output logic off_normal_n,
  output logic [ppd_pkg::PTR_W-1:0] pending
);
  localparam logic [ppd_pkg::PTR_W-1:0] P_ONE = 5'h01;

  ppd_store_if sif ();
  ppd_fig_store u_store (.mclk(mclk), .ce(ce), .st(sif));

  logic [7:0] s1_reg, s2_reg;
  logic [11:0] pre_reg;
  logic tick;
  logic [7:0] deb_reg;
  logic armed_reg;
  logic accept, reserved, wr_ok, take, recall, drop;
  logic hold_d_reg;
  logic [ppd_pkg::PTR_W-1:0] wr_ptr_reg, rd_ptr_reg, used_reg, hist_reg;
  ppd_pkg::ppd_state_t st_reg;
  logic [ppd_pkg::TCNT_W-1:0] tcnt_reg, brk_len, pause_len;
  logic [1:0] opt_reg;
  logic [3:0] pcnt_reg;
  logic dial_reg, onorm_reg;
  logic [3:0] code;
  logic stb, hold;

  function automatic logic [ppd_pkg::PTR_W-1:0] ppd_inc(input logic [ppd_pkg::PTR_W-1:0] p);
    ppd_inc = (p == ppd_pkg::STORE_DEPTH - P_ONE) ? '0 : p + P_ONE;
  endfunction : ppd_inc

  function automatic logic [ppd_pkg::PTR_W-1:0] ppd_dec(input logic [ppd_pkg::PTR_W-1:0] p);
    ppd_dec = (p == '0) ? ppd_pkg::STORE_DEPTH - P_ONE : p - P_ONE;
  endfunction : ppd_dec

  // key code to pulse count; unlisted codes give no pulses
  function automatic logic [3:0] ppd_pulses(input logic [3:0] c);
    casez (c)
      4'b0000: ppd_pulses = 4'h1;
      4'b0001: ppd_pulses = 4'h2;
      4'b0010: ppd_pulses = 4'h3;
      4'b?100: ppd_pulses = 4'h4;
      4'b01?1: ppd_pulses = 4'h5;
      4'b0110: ppd_pulses = 4'h6;
      4'b1000: ppd_pulses = 4'h7;
      4'b1??1: ppd_pulses = 4'h8;
      4'b1010: ppd_pulses = 4'h9;
      4'b0011: ppd_pulses = 4'hA;
      default: ppd_pulses = 4'h0;
    endcase
  endfunction : ppd_pulses

  // every key, strobe, hold and option pin crosses two flops before use; rst and ce are used directly
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_reg <= 8'h1E;
      s2_reg <= 8'h1E;
    end else if (ce) begin
      s1_reg <= {ratio_gnd, pause_gnd, hold_pin, strobe_n, key_n};
      s2_reg <= s1_reg;
    end
  end

  assign code = ~s2_reg[3:0];
  assign stb = ~s2_reg[4];
  assign hold = s2_reg[5];
  // options latched per figure: a pin change mid-count could otherwise skip the end match
  assign brk_len = opt_reg[1] ? ppd_pkg::BRK_GND : ppd_pkg::BRK_OPEN;
  assign pause_len = opt_reg[0] ? ppd_pkg::PAUSE_GND : ppd_pkg::PAUSE_OPEN;

  // device clock tick, stands in for the outside two-phase clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_reg <= '0;
    end else if (ce) begin
      pre_reg <= (pre_reg == tick_div - 12'h001) ? '0 : pre_reg + 12'h001;
    end
  end
  assign tick = ce && (pre_reg == tick_div - 12'h001);

  // strobe must stay asserted, then released, for a full window; bounce restarts it
  always_ff @(posedge mclk) begin
    if (rst) begin
      deb_reg <= '0;
      armed_reg <= 1'b1;
    end else if (ce) begin
      if (armed_reg != stb) begin
        deb_reg <= '0;
      end else if (tick) begin
        if (deb_reg == ppd_pkg::DEB_TICKS - 8'h01) begin
          deb_reg <= '0;
          armed_reg <= ~armed_reg;
        end else begin
          deb_reg <= deb_reg + 8'h01;
        end
      end
    end
  end
  assign accept = tick && armed_reg && stb && (deb_reg == ppd_pkg::DEB_TICKS - 8'h01);
  assign reserved = (code == ppd_pkg::CODE_RSV_F) || (code == ppd_pkg::CODE_RSV_E);
  // while held one cell stays free so the retained number cannot be overrun
  assign wr_ok = accept && !reserved &&
                 (used_reg < (hold ? ppd_pkg::HOLD_DEPTH : ppd_pkg::STORE_DEPTH));
  assign take = (st_reg == ppd_pkg::ST_FETCH);
  // a recall must not step onto the only history cell that an entry overwrites now
  assign recall = ce && hold && !hold_d_reg && (st_reg == ppd_pkg::ST_IDLE) &&
                  (hist_reg != '0) && (used_reg < ppd_pkg::HOLD_DEPTH) &&
                  !(drop && hist_reg == P_ONE);
  assign drop = wr_ok && (used_reg + hist_reg == ppd_pkg::STORE_DEPTH);

  assign sif.wr_en = wr_ok;
  assign sif.wr_addr = wr_ptr_reg;
  assign sif.wr_data = code;
  assign sif.rd_addr = rd_ptr_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_d_reg <= 1'b0;
    end else if (ce) begin
      hold_d_reg <= hold;
    end
  end

  // pointers: unsent figures follow rd_ptr, dialled ones stay behind it for recall
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      used_reg <= '0;
      hist_reg <= '0;
    end else if (ce) begin
      if (wr_ok) begin
        wr_ptr_reg <= ppd_inc(wr_ptr_reg);
      end
      if (take) begin
        rd_ptr_reg <= ppd_inc(rd_ptr_reg);
      end else if (recall) begin
        rd_ptr_reg <= ppd_dec(rd_ptr_reg);
      end
      used_reg <= used_reg + {4'h0, wr_ok} + {4'h0, recall} - {4'h0, take};
      hist_reg <= hist_reg + {4'h0, take} - {4'h0, recall} - {4'h0, drop};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= ppd_pkg::ST_IDLE;
      tcnt_reg <= '0;
      pcnt_reg <= '0;
      opt_reg <= '0;
    end else if (ce) begin
      case (st_reg)
        ppd_pkg::ST_IDLE: begin
          if (used_reg != '0 && !hold) begin
            st_reg <= ppd_pkg::ST_FETCH;
          end
        end
        ppd_pkg::ST_FETCH: st_reg <= ppd_pkg::ST_DECODE;
        ppd_pkg::ST_DECODE: begin
          pcnt_reg <= ppd_pulses(sif.rd_data);
          opt_reg <= s2_reg[7:6];
          tcnt_reg <= '0;
          st_reg <= (ppd_pulses(sif.rd_data) == 4'h0) ? ppd_pkg::ST_IDLE : ppd_pkg::ST_BREAK;
        end
        ppd_pkg::ST_BREAK: begin
          if (tick) begin
            tcnt_reg <= tcnt_reg + 15'h0001;
            if (tcnt_reg == brk_len - 15'h0001) begin
              st_reg <= ppd_pkg::ST_MAKE;
            end
          end
        end
        ppd_pkg::ST_MAKE: begin
          if (tick) begin
            if (tcnt_reg == ppd_pkg::PERIOD_LAST) begin
              tcnt_reg <= '0;
              pcnt_reg <= pcnt_reg - 4'h1;
              st_reg <= (pcnt_reg == 4'h1) ? ppd_pkg::ST_PAUSE : ppd_pkg::ST_BREAK;
            end else begin
              tcnt_reg <= tcnt_reg + 15'h0001;
            end
          end
        end
        ppd_pkg::ST_PAUSE: begin
          if (tick) begin
            tcnt_reg <= tcnt_reg + 15'h0001;
            if (tcnt_reg == pause_len - 15'h0001) begin
              st_reg <= ppd_pkg::ST_IDLE;
            end
          end
        end
        default: st_reg <= ppd_pkg::ST_IDLE;
      endcase
    end
  end

  // relay drives, low level energises the external transistor
  always_ff @(posedge mclk) begin
    if (rst) begin
      dial_reg <= 1'b0;
      onorm_reg <= 1'b0;
    end else if (ce) begin
      dial_reg <= (st_reg == ppd_pkg::ST_BREAK);
      onorm_reg <= (st_reg == ppd_pkg::ST_DECODE) || (st_reg == ppd_pkg::ST_BREAK) ||
                   (st_reg == ppd_pkg::ST_MAKE);
    end
  end
  assign dial_pulse_n = ~dial_reg;
  assign off_normal_n = ~onorm_reg;
  assign pending = used_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_store_cap: assert property (used_reg + hist_reg <= ppd_pkg::STORE_DEPTH)
    else $error("store holds more than its depth");
  chk_single_entry: assert property (ce && sif.wr_en |=> !sif.wr_en [*8])
    else $error("figure entered twice");
  chk_pulse_load: assert property (ce && st_reg == ppd_pkg::ST_DECODE |=>
      pcnt_reg == ppd_pulses($past(sif.rd_data)))
    else $error("pulse count not loaded from figure");
  chk_onorm_pause: assert property (ce && st_reg == ppd_pkg::ST_PAUSE |=> off_normal_n)
    else $error("off-normal held in pause");
  chk_dial_tie: assert property (ce |=> dial_pulse_n == ($past(st_reg) != ppd_pkg::ST_BREAK))
    else $error("dial pulse not tied to break");
  chk_period_end: assert property (ce && tick && st_reg == ppd_pkg::ST_MAKE &&
      tcnt_reg == ppd_pkg::PERIOD_LAST && pcnt_reg != 4'h1 |=> st_reg == ppd_pkg::ST_BREAK &&
      tcnt_reg == '0)
    else $error("pulse period wrong");
  chk_break_len: assert property (st_reg == ppd_pkg::ST_MAKE |-> tcnt_reg >= brk_len)
    else $error("break shorter than ratio");
  chk_no_reserved: assert property (sif.wr_en |-> sif.wr_data != ppd_pkg::CODE_RSV_F &&
      sif.wr_data != ppd_pkg::CODE_RSV_E)
    else $error("reserved code stored");
  chk_hold_block: assert property (ce && hold && st_reg == ppd_pkg::ST_IDLE |=>
      st_reg == ppd_pkg::ST_IDLE)
    else $error("dialling while held");
  chk_pause_len: assert property (st_reg == ppd_pkg::ST_PAUSE |-> tcnt_reg < pause_len)
    else $error("pause overran");
  chk_order_take: assert property (ce && take |=> rd_ptr_reg == ppd_inc($past(rd_ptr_reg)))
    else $error("read order broken");

  cov_entry: cover property (sif.wr_en);
  cov_ten_pulses: cover property (st_reg == ppd_pkg::ST_DECODE ##1 pcnt_reg == 4'hA);
  cov_recall: cover property (recall);
  cov_pause_done: cover property (st_reg == ppd_pkg::ST_PAUSE ##1 st_reg == ppd_pkg::ST_IDLE);
endmodule : ppd_dialler
`default_nettype wire

// [dv/ppd_keypad_model.sv]
// key block and relay driver model facing the pulse dialler
`default_nettype none
module ppd_keypad_model (
  input wire logic mclk,
  input wire logic dial_pulse_n,
  input wire logic off_normal_n,
  output logic [3:0] key_n,
  output logic strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int brk_run, per_run, pause_run, n_pulse, brk_len, per_len, pause_len;
  logic dp_q, on_q;
  initial begin
    key_n = 4'hF;
    strobe_n = 1'b1;
    {brk_run, per_run, pause_run, n_pulse, brk_len, per_len, pause_len} = '0;
    dp_q = 1'b1;
    on_q = 1'b1;
  end
  // relay monitor: a low drive level energises the relay
  always @(posedge mclk) begin
    dp_q <= dial_pulse_n;
    on_q <= off_normal_n;
    brk_run <= dial_pulse_n ? 0 : brk_run + 1;
    per_run <= per_run + 1;
    pause_run <= off_normal_n ? pause_run + 1 : 0;
    if (dp_q && !dial_pulse_n) begin
      n_pulse <= n_pulse + 1;
      per_len <= per_run;
      per_run <= 1;
    end
    if (!dp_q && dial_pulse_n) brk_len <= brk_run;
    if (on_q && !off_normal_n) pause_len <= pause_run;
  end
  // data settles first; the strobe bounces early, then stays closed past the window
  task automatic press(input logic [3:0] code);
    int i;
    @(posedge mclk);
    key_n <= ~code;
    repeat (20) @(posedge mclk);
    for (i = 0; i < 3; i++) begin
      strobe_n <= 1'b0;
      repeat (30) @(posedge mclk);
      strobe_n <= 1'b1;
      repeat (10) @(posedge mclk);
    end
    strobe_n <= 1'b0;
    repeat (360) @(posedge mclk);
    strobe_n <= 1'b1;
    repeat (20) @(posedge mclk);
    key_n <= 4'hF;
    repeat (300) @(posedge mclk);
  endtask : press
endmodule : ppd_keypad_model
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the pulse dialler, time base scaled to one tick per clock
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, ce, strobe_n, hold_pin, pause_gnd, ratio_gnd;
  logic [3:0] key_n;
  logic dial_pulse_n, off_normal_n;
  logic [ppd_pkg::PTR_W-1:0] pending;
  int n_fail = 0;
  int n_compared = 0;
  // one tick per clock keeps the whole run short; every count below is in ticks
  ppd_dialler #(.tick_div(12'h001)) dut (.mclk(mclk), .rst(rst), .ce(ce), .key_n(key_n),
    .strobe_n(strobe_n), .hold_pin(hold_pin), .pause_gnd(pause_gnd), .ratio_gnd(ratio_gnd),
    .dial_pulse_n(dial_pulse_n), .off_normal_n(off_normal_n), .pending(pending));
  ppd_keypad_model kb (.mclk(mclk), .dial_pulse_n(dial_pulse_n), .off_normal_n(off_normal_n),
    .key_n(key_n), .strobe_n(strobe_n));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic cmp_v(input string name, input logic [4:0] exp, input logic [4:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : cmp_v
  task automatic cmp_rng(input string name, input int lo, input int hi, input int got);
    n_compared++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("unexpected %s: expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : cmp_rng
  // follow one figure: off-normal falls, pulses run, off-normal rises for the pause
  task automatic dial(input int exp_n, input int brk, input int pause);
    int k, n0;
    k = 0;
    while (off_normal_n !== 1'b0 && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    cmp_rng("start wait", 0, 19999, k);
    @(posedge mclk);
    if (pause > 0) cmp_rng("pause", pause, pause + 8, kb.pause_len);
    n0 = kb.n_pulse;
    k = 0;
    while (off_normal_n !== 1'b1 && k < 25000) begin
      @(posedge mclk);
      k++;
    end
    cmp_rng("figure wait", 0, 24999, k);
    @(posedge mclk);
    cmp_rng("pulses", exp_n, exp_n, kb.n_pulse - n0);
    cmp_rng("break", brk - 1, brk + 2, kb.brk_len);
    if (exp_n > 1) cmp_rng("period", 2046, 2049, kb.per_len);
  endtask : dial
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    hold_pin = 1'b1;
    pause_gnd = 1'b0;
    ratio_gnd = 1'b0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    cmp_v("relays", 5'h03, {3'h0, dial_pulse_n, off_normal_n});
    cmp_v("pending", 5'h00, pending);
    // hold blocks dialling so entries pile up
    kb.press(4'h1);
    cmp_v("pending", 5'h01, pending);
    kb.press(4'hF);
    kb.press(4'hE);
    cmp_v("pending", 5'h01, pending);
    kb.press(4'h0);
    cmp_v("pending", 5'h02, pending);
    hold_pin <= 1'b0;
    dial(2, ppd_pkg::BRK_OPEN, 0);
    dial(1, ppd_pkg::BRK_OPEN, ppd_pkg::PAUSE_OPEN);
    repeat (9000) @(posedge mclk);
    cmp_v("pending", 5'h00, pending);
    // one hold pulse steps back over the last dialled figure
    hold_pin <= 1'b1;
    repeat (10) @(posedge mclk);
    cmp_v("pending", 5'h01, pending);
    pause_gnd <= 1'b1;
    ratio_gnd <= 1'b1;
    kb.press(4'h3);
    cmp_v("pending", 5'h02, pending);
    // a low enable freezes everything, so the released hold must not start dialling yet
    ce <= 1'b0;
    hold_pin <= 1'b0;
    repeat (50) @(posedge mclk);
    cmp_v("frozen relays", 5'h03, {3'h0, dial_pulse_n, off_normal_n});
    cmp_v("frozen pending", 5'h02, pending);
    ce <= 1'b1;
    dial(1, ppd_pkg::BRK_GND, 0);
    dial(10, ppd_pkg::BRK_GND, ppd_pkg::PAUSE_GND);
    cmp_v("pending", 5'h00, pending);
    end_sim();
  end
endmodule : tb
`default_nettype wire
